// file: rtl/mac_fc_pkg.sv
// Constants and helper functions of the MAC flow control, aging and timestamp block.
// Contract
// R01 - Obey received pause when receive pause enabled
// R02 - Pause time converted using configured link speed
// R03 - Congestion raised sends pause when transmit enabled
// R04 - Pause frame carries timer and source address
// R05 - Zero-pause option cancels on congestion release
// R06 - Optionally drop frames started after reaction latency
// R07 - Half duplex ignores pause, uses carrier backpressure
// R08 - Priority pause enabled per priority, own speed
// R09 - Pause class n when vector bit n set
// R10 - Priority congests when memory exceeds reserved watermark
// R11 - Priority frames only for transmit-enabled classes
// R12 - Congested priorities carry timer, others carry zero
// R13 - Protection mode also pauses all lower priorities
// R14 - Enable vector all ones, disabled entries zero
// R15 - Resend every half timer while still congested
// R16 - No zero-time priority frame on congestion clear
// R17 - Later frame gives zero to uncongested priorities
// R18 - Control selects forwarding or consuming priority pause
// R19 - Discard frames whose transit delay exceeds maximum
// R20 - Aging disable per port, count aged frames
// R21 - Timestamps are counter plus path delay
// R22 - Path delays are signed values
// R23 - Backplane mode takes reserved PTP header field
// R24 - Pause quanta are 512 bit times scaled
package mac_fc_pkg;
  localparam int NUM_PRIO = 8;
  localparam int TIMER_W = 16;
  localparam int MEM_W = 12;
  localparam int NS_W = 32;
  localparam int DELAY_W = 16;
  localparam int SPEED_W = 2;
  localparam int PRESC_W = 11;
  localparam int FIFO_DEPTH = 8;
  localparam int FRM_W = 1 + NUM_PRIO * TIMER_W;
  localparam logic [7:0] PFC_ENABLE_VECTOR = 8'hFF;
  localparam logic [TIMER_W-1:0] ZERO_TIME = 16'h0000;
  // Reserved PTP header field: byte offset of its first and its last byte.
  localparam logic [5:0] PTP_RSVD_OFFSET = 6'h10;
  localparam logic [5:0] PTP_RSVD_LAST = 6'h13;
  localparam int QUANTUM_BITS = 512;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [SPEED_W-1:0] SPEED_10M = 2'h0;
  localparam logic [SPEED_W-1:0] SPEED_100M = 2'h1;
  localparam logic [SPEED_W-1:0] SPEED_1G = 2'h2;
  localparam logic [SPEED_W-1:0] SPEED_2G5 = 2'h3;
  // Quantum length per speed in ns (in ps for 2G5), then in clock cycles rounded up.
  localparam int QUANTUM_NS_10M = QUANTUM_BITS * 100;
  localparam int QUANTUM_NS_100M = QUANTUM_BITS * 10;
  localparam int QUANTUM_NS_1G = QUANTUM_BITS;
  localparam int QUANTUM_PS_2G5 = QUANTUM_BITS * 400;
  localparam int QCYC_10M = (QUANTUM_NS_10M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCYC_100M = (QUANTUM_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCYC_1G = (QUANTUM_NS_1G + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCYC_2G5 = (QUANTUM_PS_2G5 + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);

  function automatic logic [PRESC_W-1:0] quantum_cycles(input logic [SPEED_W-1:0] speed);
    case (speed)
      SPEED_10M: quantum_cycles = PRESC_W'(QCYC_10M);
      SPEED_100M: quantum_cycles = PRESC_W'(QCYC_100M);
      SPEED_1G: quantum_cycles = PRESC_W'(QCYC_1G);
      default: quantum_cycles = PRESC_W'(QCYC_2G5);
    endcase
  endfunction

  function automatic logic [NS_W-1:0] add_signed_delay(input logic [NS_W-1:0] ns,
                                                       input logic [DELAY_W-1:0] dly);
    add_signed_delay = ns + {{(NS_W-DELAY_W){dly[DELAY_W-1]}}, dly};
  endfunction
endpackage

// file: rtl/mac_fc_fifo.sv
// Small first-word-fall-through FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module mac_fc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready_out = (count != (PW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    count <= (PW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule

// file: rtl/mac_fc_prescaler.sv
// Pause quantum tick generator: one pulse per 512 bit times at the chosen speed.
`timescale 1ns/1ps
module mac_fc_prescaler
  import mac_fc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [SPEED_W-1:0] speed_in,
  output logic tick_out
);
  logic [PRESC_W-1:0] cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else begin
      // The speed setting picks the quantum length.  see R02 see R24
      tick_out <= (cnt >= quantum_cycles(speed_in) - 1'b1);
      cnt <= (cnt >= quantum_cycles(speed_in) - 1'b1) ? '0 : cnt + 1'b1;
    end
  end
endmodule

// file: rtl/mac_fc_top.sv
// Port flow control (pause and priority pause), frame aging and timestamp adjustment.
`timescale 1ns/1ps
module mac_fc_top (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // Mode and pause configuration
  input wire logic FDX_IN,
  input wire logic PAUSE_RX_ENABLE_IN,
  input wire logic PAUSE_TX_ENABLE_IN,
  input wire logic [mac_fc_pkg::SPEED_W-1:0] PAUSE_EVAL_SPEED_IN,
  input wire logic [mac_fc_pkg::TIMER_W-1:0] PAUSE_TIMER_VALUE_IN,
  input wire logic CANCEL_WITH_ZERO_ENABLE_IN,
  input wire logic PARTNER_DROP_ENABLE_IN,
  input wire logic [mac_fc_pkg::TIMER_W-1:0] PARTNER_REACTION_LATENCY_IN,
  input wire logic [15:0] PAUSE_SRC_ADDR_HIGH_IN,
  input wire logic [31:0] PAUSE_SRC_ADDR_LOW_IN,
  input wire logic RETRY_AFTER_EXCESS_COLLISION_IN,
  // Priority pause configuration
  input wire logic [mac_fc_pkg::NUM_PRIO-1:0] PRIO_PAUSE_RX_ENABLE_IN,
  input wire logic [mac_fc_pkg::SPEED_W-1:0] PRIO_PAUSE_EVAL_SPEED_IN,
  input wire logic [mac_fc_pkg::NUM_PRIO-1:0] PRIO_PAUSE_TX_ENABLE_IN,
  input wire logic PRIORITY_PROTECTION_MODE_IN,
  input wire logic FORWARD_PRIO_PAUSE_ENABLE_IN,
  // Ingress queue congestion
  input wire logic CONGEST_IN,
  input wire logic [mac_fc_pkg::NUM_PRIO*mac_fc_pkg::MEM_W-1:0] PRIO_MEM_USE_IN,
  input wire logic [mac_fc_pkg::MEM_W-1:0] INGRESS_RESERVED_WATERMARK_IN,
  // Received control frames and frame starts
  input wire logic RX_SOF_IN,
  input wire logic RX_PAUSE_VALID_IN,
  input wire logic [mac_fc_pkg::TIMER_W-1:0] RX_PAUSE_TIME_IN,
  input wire logic RX_PRIO_PAUSE_VALID_IN,
  input wire logic [mac_fc_pkg::NUM_PRIO-1:0] RX_PRIO_VECTOR_IN,
  input wire logic [mac_fc_pkg::NUM_PRIO*mac_fc_pkg::TIMER_W-1:0] RX_PRIO_TIMES_IN,
  // Transmitted pause frame descriptors
  output logic FRM_VALID_OUT,
  input wire logic FRM_READY_IN,
  output logic FRM_PRIO_OUT,
  output logic [7:0] FRM_VECTOR_OUT,
  output logic [mac_fc_pkg::NUM_PRIO*mac_fc_pkg::TIMER_W-1:0] FRM_TIMES_OUT,
  output logic [47:0] FRM_SRC_ADDR_OUT,
  // Egress pause and link status
  output logic EGRESS_PAUSE_OUT,
  output logic [mac_fc_pkg::NUM_PRIO-1:0] PRIO_PAUSE_OUT,
  output logic CARRIER_BP_OUT,
  output logic RETRY_EXC_COL_OUT,
  output logic RX_DROP_OUT,
  output logic RX_PRIO_FORWARD_OUT,
  output logic [mac_fc_pkg::NUM_PRIO-1:0] PRIO_CONGEST_OUT,
  // Frame aging
  input wire logic [mac_fc_pkg::NS_W-1:0] MAX_TRANSIT_DELAY_IN,
  input wire logic AGING_DISABLE_IN,
  input wire logic EGR_SCHED_IN,
  input wire logic [mac_fc_pkg::NS_W-1:0] EGR_RX_DONE_TIME_IN,
  output logic EGR_PASS_OUT,
  output logic EGR_DISCARD_OUT,
  output logic [31:0] AGED_COUNT_OUT,
  // Timestamps
  input wire logic [mac_fc_pkg::NS_W-1:0] NS_COUNTER_IN,
  input wire logic [mac_fc_pkg::DELAY_W-1:0] RX_PATH_DELAY_IN,
  input wire logic [mac_fc_pkg::DELAY_W-1:0] TX_PATH_DELAY_IN,
  input wire logic INGRESS_BACKPLANE_MODE_IN,
  input wire logic TX_SOF_IN,
  input wire logic PTP_HDR_START_IN,
  input wire logic PTP_HDR_VALID_IN,
  input wire logic [7:0] PTP_HDR_BYTE_IN,
  output logic RX_TS_VALID_OUT,
  output logic [mac_fc_pkg::NS_W-1:0] RX_TS_OUT,
  output logic TX_TS_VALID_OUT,
  output logic [mac_fc_pkg::NS_W-1:0] TX_TS_OUT
);
  import mac_fc_pkg::*;

  //----------------------------------------------------------------
  // Quantum ticks
  //----------------------------------------------------------------
  logic tick_std;
  logic tick_prio;

  mac_fc_prescaler u_presc_std (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .speed_in(PAUSE_EVAL_SPEED_IN),
    .tick_out(tick_std)
  );

  mac_fc_prescaler u_presc_prio (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .speed_in(PRIO_PAUSE_EVAL_SPEED_IN),
    .tick_out(tick_prio)
  );

  //----------------------------------------------------------------
  // Received pause handling
  //----------------------------------------------------------------
  logic [TIMER_W-1:0] std_left;
  logic [TIMER_W-1:0] prio_left [NUM_PRIO];

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      std_left <= '0;
    end else if (!FDX_IN) begin
      std_left <= '0; // see R07
    end else if (RX_PAUSE_VALID_IN && PAUSE_RX_ENABLE_IN) begin
      std_left <= RX_PAUSE_TIME_IN; // see R01
    end else if (tick_std && std_left != '0) begin
      std_left <= std_left - 1'b1; // see R24
    end
  end
  assign EGRESS_PAUSE_OUT = (std_left != '0);

  for (genvar i = 0; i < NUM_PRIO; i++) begin : g_rx_prio
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
        prio_left[i] <= '0;
      end else if (!FDX_IN) begin
        prio_left[i] <= '0;
      end else if (RX_PRIO_PAUSE_VALID_IN && PRIO_PAUSE_RX_ENABLE_IN[i] && RX_PRIO_VECTOR_IN[i]) begin
        prio_left[i] <= RX_PRIO_TIMES_IN[i*TIMER_W +: TIMER_W]; // see R08 see R09
      end else if (tick_prio && prio_left[i] != '0) begin
        prio_left[i] <= prio_left[i] - 1'b1;
      end
    end
    assign PRIO_PAUSE_OUT[i] = (prio_left[i] != '0);
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RX_PRIO_FORWARD_OUT <= 1'b0;
    end else begin
      RX_PRIO_FORWARD_OUT <= RX_PRIO_PAUSE_VALID_IN && FORWARD_PRIO_PAUSE_ENABLE_IN; // see R18
    end
  end

  //----------------------------------------------------------------
  // Congestion tracking and half duplex backpressure
  //----------------------------------------------------------------
  logic [NUM_PRIO-1:0] prio_cong;
  logic [NUM_PRIO-1:0] prio_act;
  logic [NUM_PRIO-1:0] prio_act_prev;
  logic [NUM_PRIO-1:0] prio_paused;
  logic cong_prev;

  for (genvar i = 0; i < NUM_PRIO; i++) begin : g_cong
    assign prio_cong[i] = PRIO_MEM_USE_IN[i*MEM_W +: MEM_W] > INGRESS_RESERVED_WATERMARK_IN; // see R10
    // In protection mode a congested, transmit-enabled higher class drags all lower classes along.  see R13
    // A class disabled for flow control keeps a zero time even when dragged along.  see R14
    assign prio_paused[i] = PRIO_PAUSE_TX_ENABLE_IN[i]
                            && (PRIORITY_PROTECTION_MODE_IN ? (|prio_act[NUM_PRIO-1:i]) : prio_act[i]);
  end
  assign prio_act = prio_cong & PRIO_PAUSE_TX_ENABLE_IN & {NUM_PRIO{FDX_IN}}; // see R11
  assign PRIO_CONGEST_OUT = prio_cong;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cong_prev <= 1'b0;
      prio_act_prev <= '0;
    end else begin
      cong_prev <= CONGEST_IN;
      prio_act_prev <= prio_act;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CARRIER_BP_OUT <= 1'b0;
      RETRY_EXC_COL_OUT <= 1'b0;
    end else begin
      CARRIER_BP_OUT <= !FDX_IN && CONGEST_IN; // see R07
      RETRY_EXC_COL_OUT <= !FDX_IN && RETRY_AFTER_EXCESS_COLLISION_IN;
    end
  end

  //----------------------------------------------------------------
  // Pause frame requests
  //----------------------------------------------------------------
  logic std_pend;
  logic [TIMER_W-1:0] std_pend_time;
  logic prio_pend;
  logic [TIMER_W-1:0] rep_left;
  logic fifo_ready;
  logic push_std;
  logic push_prio;
  logic [FRM_W-1:0] push_data;
  logic [NUM_PRIO*TIMER_W-1:0] prio_times;
  logic [FRM_W-1:0] pop_data;

  for (genvar i = 0; i < NUM_PRIO; i++) begin : g_tx_times
    // Disabled classes, and uncongested ones not dragged along by protection mode, carry zero.  see R12 see R14 see R17
    assign prio_times[i*TIMER_W +: TIMER_W] = prio_paused[i] ? PAUSE_TIMER_VALUE_IN : ZERO_TIME;
  end

  // The standard request wins the single push slot; the priority one waits.
  assign push_std = std_pend && fifo_ready;
  assign push_prio = prio_pend && !std_pend && fifo_ready;
  assign push_data = push_std ? {1'b0, {((NUM_PRIO-1)*TIMER_W){1'b0}}, std_pend_time} : {1'b1, prio_times};

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      std_pend <= 1'b0;
      std_pend_time <= '0;
    end else if (FDX_IN && PAUSE_TX_ENABLE_IN && CONGEST_IN && !cong_prev) begin
      std_pend <= 1'b1; // see R03
      std_pend_time <= PAUSE_TIMER_VALUE_IN; // see R04
    end else if (FDX_IN && PAUSE_TX_ENABLE_IN && CANCEL_WITH_ZERO_ENABLE_IN && !CONGEST_IN && cong_prev) begin
      std_pend <= 1'b1; // see R05
      std_pend_time <= ZERO_TIME;
    end else if (push_std) begin
      std_pend <= 1'b0;
    end
  end

  // Clearing priority congestion never queues a frame; the partner timer runs out.  see R16
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      prio_pend <= 1'b0;
    end else if ((prio_act & ~prio_act_prev) != '0) begin
      prio_pend <= 1'b1;
    end else if (prio_act != '0 && rep_left == '0 && !prio_pend) begin
      prio_pend <= 1'b1; // see R15
    end else if (push_prio) begin
      prio_pend <= 1'b0;
    end
  end

  // Spacing between repeats is half the configured timer, in quanta.
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rep_left <= '0;
    end else if (push_prio) begin
      rep_left <= PAUSE_TIMER_VALUE_IN >> 1; // see R15
    end else if (tick_std && rep_left != '0) begin
      rep_left <= rep_left - 1'b1;
    end
  end

  mac_fc_fifo #(
    .WIDTH(FRM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_frm_fifo (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .in_valid_in(push_std || push_prio),
    .in_ready_out(fifo_ready),
    .in_data_in(push_data),
    .out_valid_out(FRM_VALID_OUT),
    .out_ready_in(FRM_READY_IN),
    .out_data_out(pop_data)
  );
  assign FRM_PRIO_OUT = pop_data[FRM_W-1];
  assign FRM_TIMES_OUT = pop_data[FRM_W-2:0];
  assign FRM_VECTOR_OUT = pop_data[FRM_W-1] ? PFC_ENABLE_VECTOR : 8'h00; // see R14
  assign FRM_SRC_ADDR_OUT = {PAUSE_SRC_ADDR_HIGH_IN, PAUSE_SRC_ADDR_LOW_IN}; // see R04

  //----------------------------------------------------------------
  // Non-complying partner guard
  //----------------------------------------------------------------
  logic [TIMER_W-1:0] lat_left;
  logic [TIMER_W-1:0] guard_left;

  // The guard covers our own sent pause time; a zero frame ends it at once.
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lat_left <= '0;
      guard_left <= '0;
    end else if (FRM_VALID_OUT && FRM_READY_IN) begin
      lat_left <= PARTNER_REACTION_LATENCY_IN;
      guard_left <= pop_data[FRM_W-1] ? PAUSE_TIMER_VALUE_IN : pop_data[TIMER_W-1:0];
    end else if (tick_std) begin
      if (lat_left != '0) begin
        lat_left <= lat_left - 1'b1;
      end
      if (guard_left != '0) begin
        guard_left <= guard_left - 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RX_DROP_OUT <= 1'b0;
    end else begin
      RX_DROP_OUT <= PARTNER_DROP_ENABLE_IN && RX_SOF_IN && lat_left == '0 && guard_left != '0; // see R06
    end
  end

  //----------------------------------------------------------------
  // Frame aging
  //----------------------------------------------------------------
  logic [NS_W-1:0] transit;
  logic aged;
  assign transit = NS_COUNTER_IN - EGR_RX_DONE_TIME_IN;
  assign aged = !AGING_DISABLE_IN && transit > MAX_TRANSIT_DELAY_IN; // see R19 see R20

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      EGR_PASS_OUT <= 1'b0;
      EGR_DISCARD_OUT <= 1'b0;
      AGED_COUNT_OUT <= '0;
    end else begin
      EGR_PASS_OUT <= EGR_SCHED_IN && !aged;
      EGR_DISCARD_OUT <= EGR_SCHED_IN && aged;
      if (EGR_SCHED_IN && aged) begin
        AGED_COUNT_OUT <= AGED_COUNT_OUT + 1'b1; // see R20
      end
    end
  end

  //----------------------------------------------------------------
  // Timestamps
  //----------------------------------------------------------------
  logic [5:0] hdr_idx;
  logic [NS_W-1:0] rsvd;
  logic rsvd_done;

  // Bytes of the reserved field are gathered most significant first.
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hdr_idx <= '0;
      rsvd <= '0;
    end else if (PTP_HDR_START_IN) begin
      hdr_idx <= '0;
    end else if (PTP_HDR_VALID_IN && hdr_idx <= PTP_RSVD_LAST) begin
      hdr_idx <= hdr_idx + 1'b1;
      if (hdr_idx >= PTP_RSVD_OFFSET) begin
        rsvd <= {rsvd[NS_W-9:0], PTP_HDR_BYTE_IN}; // see R23
      end
    end
  end
  assign rsvd_done = PTP_HDR_VALID_IN && hdr_idx == PTP_RSVD_LAST;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RX_TS_VALID_OUT <= 1'b0;
      RX_TS_OUT <= '0;
    end else if (INGRESS_BACKPLANE_MODE_IN) begin
      RX_TS_VALID_OUT <= rsvd_done;
      if (rsvd_done) begin
        RX_TS_OUT <= {rsvd[NS_W-9:0], PTP_HDR_BYTE_IN}; // see R23
      end
    end else begin
      RX_TS_VALID_OUT <= RX_SOF_IN;
      if (RX_SOF_IN) begin
        RX_TS_OUT <= add_signed_delay(NS_COUNTER_IN, RX_PATH_DELAY_IN); // see R21 see R22
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TX_TS_VALID_OUT <= 1'b0;
      TX_TS_OUT <= '0;
    end else begin
      TX_TS_VALID_OUT <= TX_SOF_IN;
      if (TX_SOF_IN) begin
        TX_TS_OUT <= add_signed_delay(NS_COUNTER_IN, TX_PATH_DELAY_IN); // see R21 see R22
      end
    end
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  AST_RX_PAUSE_OBEY: assert property ( // see R01
    FDX_IN && PAUSE_RX_ENABLE_IN && RX_PAUSE_VALID_IN && RX_PAUSE_TIME_IN != '0 |=> EGRESS_PAUSE_OUT)
    else $error("received pause not obeyed");
  AST_HDX_NO_PAUSE: assert property ( // see R07
    !FDX_IN |=> !EGRESS_PAUSE_OUT && PRIO_PAUSE_OUT == '0) else $error("pause active in half duplex");
  AST_HDX_BACKPRESSURE: assert property ( // see R07
    !FDX_IN && CONGEST_IN |=> CARRIER_BP_OUT) else $error("no backpressure under congestion");
  AST_PRIO_CLASS0: assert property ( // see R09
    FDX_IN && RX_PRIO_PAUSE_VALID_IN && PRIO_PAUSE_RX_ENABLE_IN[0] && RX_PRIO_VECTOR_IN[0]
    && RX_PRIO_TIMES_IN[TIMER_W-1:0] != '0 |=> PRIO_PAUSE_OUT[0]) else $error("class 0 not paused");
  AST_PFC_VECTOR: assert property ( // see R14
    FRM_VALID_OUT && FRM_PRIO_OUT |-> FRM_VECTOR_OUT == 8'hFF) else $error("enable vector not all ones");
  AST_STD_SEND: assert property ( // see R03
    FDX_IN && PAUSE_TX_ENABLE_IN && CONGEST_IN && !cong_prev |=> std_pend ##[0:8] push_std)
    else $error("pause frame not queued");
  AST_AGE_DROP: assert property ( // see R19
    EGR_SCHED_IN && !AGING_DISABLE_IN && (NS_COUNTER_IN - EGR_RX_DONE_TIME_IN) > MAX_TRANSIT_DELAY_IN
    |=> EGR_DISCARD_OUT && !EGR_PASS_OUT) else $error("aged frame not discarded");
  AST_AGE_COUNT: assert property ( // see R20
    EGR_DISCARD_OUT |-> AGED_COUNT_OUT == $past(AGED_COUNT_OUT) + 1) else $error("aged counter missed");
  AST_RX_TS: assert property ( // see R21
    RX_SOF_IN && !INGRESS_BACKPLANE_MODE_IN |=> RX_TS_VALID_OUT
    && RX_TS_OUT == add_signed_delay($past(NS_COUNTER_IN), $past(RX_PATH_DELAY_IN))) else $error("bad rx stamp");
  AST_TX_TS: assert property ( // see R22
    TX_SOF_IN |=> TX_TS_OUT == add_signed_delay($past(NS_COUNTER_IN), $past(TX_PATH_DELAY_IN)))
    else $error("bad tx stamp");
  AST_FORWARD: assert property ( // see R18
    RX_PRIO_PAUSE_VALID_IN && !FORWARD_PRIO_PAUSE_ENABLE_IN |=> !RX_PRIO_FORWARD_OUT) else $error("pause forwarded");

  COV_PFC_SENT: cover property (FRM_VALID_OUT && FRM_READY_IN && FRM_PRIO_OUT);
  COV_ZERO_PAUSE: cover property (push_std && std_pend_time == '0);
  COV_PARTNER_DROP: cover property (RX_DROP_OUT);
endmodule

// file: test/mac_fc_partner.sv
// Far-side sink of pause descriptors, prompt or stalled on command.
`timescale 1ns/1ps
module mac_fc_partner (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Descriptor handshake
  input wire logic valid_in,
  input wire logic stall_in,
  output logic ready_out,
  output int got_out
);
  assign ready_out = !stall_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      got_out <= 0;
    end else if (valid_in && ready_out) begin
      got_out <= got_out + 1;
    end
  end
endmodule

// file: test/mac_fc_top_bench.sv
// Self-checking bench for the flow control, aging and timestamp block.
`timescale 1ns/1ps
module mac_fc_top_bench;
  logic CLK_SYS_IN = 0, RST_N_IN = 0, FDX_IN = 1, PAUSE_RX_ENABLE_IN = 1, PAUSE_TX_ENABLE_IN = 1;
  logic CANCEL_WITH_ZERO_ENABLE_IN = 1, PARTNER_DROP_ENABLE_IN = 0, RETRY_AFTER_EXCESS_COLLISION_IN = 1;
  logic PRIORITY_PROTECTION_MODE_IN = 1, FORWARD_PRIO_PAUSE_ENABLE_IN = 1, CONGEST_IN = 0, AGING_DISABLE_IN = 0;
  logic INGRESS_BACKPLANE_MODE_IN = 0, PTP_HDR_START_IN = 0, PTP_HDR_VALID_IN = 0, stall = 0;
  // One-cycle strobes share a vector so a single task can raise any mix of them.
  localparam logic [4:0] P_RX_PAUSE = 5'h10, P_RX_PRIO = 5'h08, P_RX_SOF = 5'h04, P_TX_SOF = 5'h02, P_SCHED = 5'h01;
  logic [4:0] pulse_sel = 5'h00;
  logic RX_PAUSE_VALID_IN, RX_PRIO_PAUSE_VALID_IN, RX_SOF_IN, TX_SOF_IN, EGR_SCHED_IN;
  assign {RX_PAUSE_VALID_IN, RX_PRIO_PAUSE_VALID_IN, RX_SOF_IN, TX_SOF_IN, EGR_SCHED_IN} = pulse_sel;
  logic [1:0] PAUSE_EVAL_SPEED_IN = 2'h2, PRIO_PAUSE_EVAL_SPEED_IN = 2'h2;
  logic [15:0] PAUSE_TIMER_VALUE_IN = 16'h0005, PARTNER_REACTION_LATENCY_IN = 16'h0001;
  logic [15:0] RX_PAUSE_TIME_IN = 16'h0002, PAUSE_SRC_ADDR_HIGH_IN = 16'hA1B2;
  logic [15:0] RX_PATH_DELAY_IN = 16'hFFF0, TX_PATH_DELAY_IN = 16'h0020;
  logic [31:0] PAUSE_SRC_ADDR_LOW_IN = 32'hC3D4E5F6, MAX_TRANSIT_DELAY_IN = 32'h64;
  logic [31:0] EGR_RX_DONE_TIME_IN = 32'h320, NS_COUNTER_IN = 32'h3E8, AGED_COUNT_OUT, RX_TS_OUT, TX_TS_OUT;
  logic [7:0] PRIO_PAUSE_RX_ENABLE_IN = 8'h03, PRIO_PAUSE_TX_ENABLE_IN = 8'h0D, RX_PRIO_VECTOR_IN = 8'h07;
  logic [7:0] PTP_HDR_BYTE_IN = 8'h00, FRM_VECTOR_OUT, PRIO_PAUSE_OUT, PRIO_CONGEST_OUT;
  logic [11:0] INGRESS_RESERVED_WATERMARK_IN = 12'h010;
  logic [95:0] PRIO_MEM_USE_IN = '0;
  logic [127:0] RX_PRIO_TIMES_IN = {8{16'h0001}}, FRM_TIMES_OUT;
  logic [47:0] FRM_SRC_ADDR_OUT;
  logic FRM_VALID_OUT, FRM_READY_IN, FRM_PRIO_OUT, EGRESS_PAUSE_OUT, CARRIER_BP_OUT, RETRY_EXC_COL_OUT;
  logic RX_DROP_OUT, RX_PRIO_FORWARD_OUT, EGR_PASS_OUT, EGR_DISCARD_OUT, RX_TS_VALID_OUT, TX_TS_VALID_OUT;
  int fail_count = 0, comparisons = 0, got;
  mac_fc_top dut_u (.*);
  mac_fc_partner model_u (.clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .valid_in(FRM_VALID_OUT),
    .stall_in(stall), .ready_out(FRM_READY_IN), .got_out(got));
  always #20 CLK_SYS_IN = ~CLK_SYS_IN;
  task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Polls on falling edges so every check sees settled outputs.
  task automatic wait_frm;
    for (int i = 0; i < 60 && FRM_VALID_OUT !== 1'b1; i++) @(negedge CLK_SYS_IN);
    if (FRM_VALID_OUT !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic pulse(input logic [4:0] sel);
    @(posedge CLK_SYS_IN);
    pulse_sel <= sel;
    @(posedge CLK_SYS_IN);
    pulse_sel <= 5'h00;
    @(negedge CLK_SYS_IN);
  endtask
  task automatic t_std;
    @(posedge CLK_SYS_IN);
    CONGEST_IN <= 1;
    stall <= 1;
    wait_frm();
    repeat (4) @(negedge CLK_SYS_IN);
    chk({FRM_VALID_OUT, FRM_PRIO_OUT, FRM_TIMES_OUT}, {2'h2, 128'h5});
    chk(FRM_SRC_ADDR_OUT, 48'hA1B2C3D4E5F6);
    @(posedge CLK_SYS_IN);
    stall <= 0;
    CONGEST_IN <= 0;
    repeat (2) @(negedge CLK_SYS_IN);
    chk(got, 1);
    wait_frm();
    chk({FRM_VALID_OUT, FRM_PRIO_OUT, FRM_TIMES_OUT}, {2'h2, 128'h0});
    $display("Standard pause test done");
  endtask
  task automatic t_prio;
    @(posedge CLK_SYS_IN);
    PRIO_MEM_USE_IN <= {24'h0, 12'h020, 24'h0, 12'h011, 24'h0};
    @(negedge CLK_SYS_IN);
    wait_frm();
    chk(PRIO_CONGEST_OUT, 8'h24);
    chk({FRM_PRIO_OUT, FRM_VECTOR_OUT}, 9'h1FF);
    chk(FRM_TIMES_OUT, {80'h0, 16'h0005, 16'h0000, 16'h0005});
    @(negedge CLK_SYS_IN);
    wait_frm();
    chk(got, 3);
    @(posedge CLK_SYS_IN);
    PRIO_MEM_USE_IN <= '0;
    PARTNER_DROP_ENABLE_IN <= 1;
    repeat (30) @(negedge CLK_SYS_IN);
    pulse(P_RX_SOF);
    chk(RX_DROP_OUT, 1'h1);
    repeat (60) @(negedge CLK_SYS_IN);
    chk(got, 4);
    pulse(P_RX_SOF);
    chk(RX_DROP_OUT, 1'h0);
    $display("Priority pause test done");
  endtask
  task automatic t_rx;
    pulse(P_RX_PAUSE);
    repeat (11) @(negedge CLK_SYS_IN);
    chk(EGRESS_PAUSE_OUT, 1'h1);
    repeat (33) @(negedge CLK_SYS_IN);
    chk(EGRESS_PAUSE_OUT, 1'h0);
    pulse(P_RX_PRIO);
    chk({PRIO_PAUSE_OUT, RX_PRIO_FORWARD_OUT}, 9'h007);
    @(posedge CLK_SYS_IN);
    FDX_IN <= 0;
    CONGEST_IN <= 1;
    FORWARD_PRIO_PAUSE_ENABLE_IN <= 0;
    pulse(P_RX_PAUSE | P_RX_PRIO);
    chk({EGRESS_PAUSE_OUT, PRIO_PAUSE_OUT, CARRIER_BP_OUT, RETRY_EXC_COL_OUT, RX_PRIO_FORWARD_OUT}, 12'h006);
    $display("Receive pause test done");
  endtask
  task automatic t_ts_age;
    pulse(P_RX_SOF);
    chk({RX_TS_VALID_OUT, RX_TS_OUT}, 33'h1000003D8);
    pulse(P_TX_SOF);
    chk({TX_TS_VALID_OUT, TX_TS_OUT}, 33'h100000408);
    pulse(P_SCHED);
    chk({EGR_DISCARD_OUT, EGR_PASS_OUT, AGED_COUNT_OUT}, 34'h200000001);
    @(posedge CLK_SYS_IN);
    AGING_DISABLE_IN <= 1;
    pulse(P_SCHED);
    chk({EGR_DISCARD_OUT, EGR_PASS_OUT, AGED_COUNT_OUT}, 34'h100000001);
    @(posedge CLK_SYS_IN);
    INGRESS_BACKPLANE_MODE_IN <= 1;
    PTP_HDR_START_IN <= 1;
    for (int i = 0; i < 20; i++) begin
      @(posedge CLK_SYS_IN);
      PTP_HDR_START_IN <= 0;
      PTP_HDR_VALID_IN <= 1;
      PTP_HDR_BYTE_IN <= 8'(i + 1);
    end
    @(posedge CLK_SYS_IN);
    PTP_HDR_VALID_IN <= 0;
    @(negedge CLK_SYS_IN);
    chk({RX_TS_VALID_OUT, RX_TS_OUT}, 33'h111121314);
    $display("Timestamp and aging test done");
  endtask
  initial begin
    repeat (3) @(posedge CLK_SYS_IN);
    RST_N_IN <= 1;
    t_std();
    t_prio();
    t_rx();
    t_ts_age();
    wrap_up();
  end
endmodule
